/* File: temp_sensor_serial_alert_logic_tb.sv */
/*
 * Self-checking bench for the two-wire slave and alert logic.
 * Assumes tsa_master as bus master; pull-ups on SDA and the alert pin.
 */
`timescale 1ns/1ns
module temp_sensor_serial_alert_logic_tb;
	import tsa_pkg::*;
	localparam int          TO  = 200;
	localparam logic [15:0] OVR = 16'h2360;
	localparam logic [15:0] MID = 16'h1A50;
	localparam logic [15:0] CLD = 16'h1A40;
	logic        i_clk, i_rst, scl, m_lo, sda, sda_oe_n, al_oe_n;
	logic        sda_o, al_o, al_pin;
	logic        shut, shot, tv, ak, pol;
	logic [2:0]  pins;
	logic [6:0]  a;
	logic [15:0] temp, d;
	tsa_cfg_t    cfg;
	int          n_errors, n_tests, n_shot;
	int          need[4] = '{1, 2, 4, 6};

	// Open drain wires with pull-ups: driven level only while enabled
	assign sda    = ~m_lo & (sda_oe_n | sda_o);
	assign al_pin = al_oe_n | al_o;
	assign a = {ADDR_FIXED, 3'h0};

	tsa_top #(.TIMEOUT_CYC(TO)) i_dut
	(
		.i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
		.o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n),
		.i_addr_select_bit2(pins[2]), .i_addr_select_bit1(pins[1]),
		.i_addr_select_bit0(pins[0]), .i_temp(temp), .i_temp_valid(tv),
		.o_overtemp_alert_output_o(al_o),
		.o_overtemp_alert_output_oe_n(al_oe_n),
		.o_shutdown(shut), .o_oneshot(shot)
	);
	tsa_master i_mst(.i_sda(sda), .o_scl(scl), .o_sda_lo(m_lo));

	// ----------------------------------------
	// Clock, watchdog and helpers
	// ----------------------------------------
	initial
	begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	initial
	begin
		#2_000_000;
		n_errors++;
		print_verdict();
	end

	always @(posedge i_clk)
		if (shot === 1'b1)
			n_shot++;

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// One direction per frame, a new start for each
	task automatic wr(input logic [6:0] ad, input logic [7:0] p,
		input logic [15:0] v, input int n);
		logic k;
		i_mst.start();
		i_mst.put({ad, 1'b0}, ak);
		i_mst.put(p, k);
		for (int i = n; i > 0; i--)
			i_mst.put(v[8*i-1 -: 8], k);
		i_mst.stop();
	endtask

	task automatic rd(input logic [6:0] ad, input int n);
		logic [7:0] b;
		d = 16'h0000;
		i_mst.start();
		i_mst.put({ad, 1'b1}, ak);
		for (int i = 1; i <= n; i++)
		begin
			i_mst.get(i == n, b);
			d = {d[7:0], b};
		end
		i_mst.stop();
	endtask

	task automatic rreg(input logic [2:0] p, input int n);
		wr(a, {5'h00, p}, 16'h0000, 0);
		rd(a, n);
	endtask

	task automatic samp(input logic [15:0] t);
		@(negedge i_clk);
		temp = t;
		tv = 1'b1;
		@(negedge i_clk);
		tv = 1'b0;
		repeat (3) @(negedge i_clk);
	endtask

	task automatic pin(input logic act);
		check({15'h0000, al_pin}, {15'h0000, act ~^ pol});
	endtask

	task automatic setcfg(input logic [7:0] c);
		wr(a, {5'h00, PTR_CFG}, {8'h00, c}, 1);
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		i_rst = 1'b1;
		pins = 3'h0;
		temp = 16'h0000;
		tv = 1'b0;
		pol = 1'b0;
		n_errors = 0;
		n_tests = 0;
		n_shot = 0;
		repeat (2) @(negedge i_clk);
		i_rst = 1'b0;
		repeat (3) @(negedge i_clk);
		pin(1'b0);
		rd(a, 2);
		check(d, TEMP_RST);
		rreg(PTR_CFG, 1);
		check(d, {8'h00, CFG_RST});
		rreg(PTR_HYST, 2);
		check(d, HYST_RST);
		rreg(PTR_OVER, 2);
		check(d, OVER_RST);
		$display("Reset values done");

		for (int p = 0; p < 8; p++)
		begin
			@(negedge i_clk);
			pins = p[2:0];
			repeat (4) @(negedge i_clk);
			rd({ADDR_FIXED, p[2:0]}, 1);
			check({15'h0000, ak}, 16'h0000);
			check(d, 16'h0050);
			rd({ADDR_FIXED, ~p[2:0]}, 2);
			check({15'h0000, ak}, 16'h0001);
			check(d, 16'hFFFF);
		end
		@(negedge i_clk);
		pins = 3'h0;
		$display("Address select done");

		wr(a, {5'h00, PTR_HYST}, MID, 2);
		wr(a, {5'h00, PTR_OVER}, OVR, 2);
		rreg(PTR_HYST, 2);
		check(d, MID);
		rreg(PTR_OVER, 2);
		check(d, OVR);
		wr(a, 8'hFC, 16'h0000, 0);
		check(n_shot[15:0], 16'h0001);
		rd(a, 2);
		check(d, 16'h0000);
		$display("Limit registers done");

		for (int q = 0; q < 4; q++)
			for (int pl = 0; pl < 2; pl++)
			begin
				cfg = '0;
				cfg.fault_q = q[1:0];
				cfg.pol_high = pl[0];
				pol = pl[0];
				setcfg(cfg);
				wr(a, 8'hF9, 16'h0000, 0);
				rd(a, 1);
				check(d, {8'h00, cfg});
				samp(CLD);
				pin(1'b0);
				repeat (need[q] - 1) samp(OVR);
				samp(MID);
				repeat (need[q] - 1) samp(OVR);
				pin(1'b0);
				samp(OVR);
				pin(1'b1);
				samp(MID);
				pin(1'b1);
				samp(CLD);
				pin(1'b0);
			end
		pol = 1'b0;
		$display("Comparator and fault queue done");

		setcfg(8'h00);
		samp(OVR);
		setcfg(8'h01);
		check({15'h0000, shut}, 16'h0001);
		pin(1'b1);
		samp(CLD);
		pin(1'b1);
		rreg(PTR_TEMP, 2);
		check(d, OVR);
		setcfg(8'h00);
		check({15'h0000, shut}, 16'h0000);
		samp(CLD);
		pin(1'b0);
		rreg(PTR_TEMP, 2);
		check(d, CLD);
		$display("Shutdown done");

		setcfg(8'h02);
		samp(OVR);
		pin(1'b1);
		rd(a, 1);
		pin(1'b0);
		samp(OVR);
		pin(1'b0);
		samp(MID);
		samp(OVR);
		pin(1'b1);
		rd(a, 1);
		pin(1'b0);
		setcfg(8'h00);
		$display("Interrupt mode done");

		wr(a, {5'h00, PTR_OVER}, 16'h0000, 0);
		i_mst.start();
		i_mst.put({a, 1'b1}, ak);
		repeat (4) @(negedge i_clk);
		check({15'h0000, sda_oe_n}, 16'h0000);
		repeat (TO + 20) @(negedge i_clk);
		check({15'h0000, sda_oe_n}, 16'h0001);
		i_mst.stop();
		i_mst.start();
		i_mst.put({a, 1'b0}, ak);
		i_mst.put({5'h00, PTR_CFG}, ak);
		repeat (3 * TO) @(negedge i_clk);
		i_mst.put(8'h08, ak);
		i_mst.stop();
		check({15'h0000, ak}, 16'h0000);
		rd(a, 1);
		check(d, 16'h0008);
		$display("Bus timeout done");
		print_verdict();
	end
endmodule

/* File: tsa_alert.sv */
/*
 * Fault queue and alert pin logic, comparator and interrupt behaviour.
 * Assumes measurement strobes and register-read pulses on the system clock.
 */
`timescale 1ns/1ns
module tsa_alert
(
	input  logic              i_clk,
	input  logic              i_rst,
	input  tsa_pkg::tsa_cfg_t i_cfg,
	input  logic [15:0]       i_temp,
	input  logic              i_temp_valid,
	input  logic [15:0]       i_over,
	input  logic [15:0]       i_hyst,
	input  logic              i_rd_clear,
	output logic              o_alert_oe_n
);
	import tsa_pkg::*;

	logic [2:0] need;
	logic [2:0] cnt_r;
	logic [2:0] cnt_inc;
	logic       sample;
	logic       over;
	logic       below;
	logic       reach;
	logic       hit;
	logic       cmp_r;
	logic       int_r;
	logic       act;
	logic       oe_n_r;

	assign need    = fault_need(i_cfg.fault_q);                // RULE1
	// Shutdown stops measuring, so no strobe is taken then
	assign sample  = i_temp_valid & ~i_cfg.shutdown;          // RULE4 RULE21
	assign over    = $signed(i_temp) >= $signed(i_over);
	assign below   = $signed(i_temp) < $signed(i_hyst);
	assign cnt_inc = 3'(cnt_r + 3'h1);
	assign reach   = sample & over & (cnt_inc >= need);
	assign hit     = sample & over & (cnt_inc == need);
	assign act     = i_cfg.int_mode ? int_r : cmp_r;          // RULE3

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			cnt_r <= 3'h0;
		else if (sample && !over)
			cnt_r <= 3'h0;                                    // RULE24
		else if (sample && cnt_r < need)
			cnt_r <= cnt_inc;
	end

	// Shutdown leaves the comparator state frozen rather than cleared
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			cmp_r <= 1'b0;                                    // RULE19
		else if (reach)
			cmp_r <= 1'b1;                                    // RULE20
		else if (sample && below)
			cmp_r <= 1'b0;                                    // RULE20
	end

	// Set wins over a read clear in the same cycle
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			int_r <= 1'b0;
		else if (hit && i_cfg.int_mode)
			int_r <= 1'b1;                                    // RULE22
		else if (i_rd_clear || !i_cfg.int_mode)
			int_r <= 1'b0;
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			oe_n_r <= 1'b1;
		else
			oe_n_r <= ~(act ^ i_cfg.pol_high);                // RULE2
	end

	assign o_alert_oe_n = oe_n_r;

	fault_reset_a: // RULE24
	assert property (@(posedge i_clk) disable iff (i_rst)
		sample && !over |=> cnt_r == 3'h0)
	else $error("fault count not restarted by in-limit sample");

	cmp_alert_a: // RULE20
	assert property (@(posedge i_clk) disable iff (i_rst)
		!i_cfg.int_mode && reach && !i_cfg.pol_high
		##1 !i_cfg.int_mode && !i_cfg.pol_high |=> !oe_n_r)
	else $error("comparator alert not driven after reaching limit");

	shut_hold_a: // RULE21
	assert property (@(posedge i_clk) disable iff (i_rst)
		i_cfg.shutdown |=> $stable(cmp_r))
	else $error("comparator state changed in shutdown");

	int_clear_a: // RULE22
	assert property (@(posedge i_clk) disable iff (i_rst)
		int_r && i_rd_clear && !hit |=> !int_r)
	else $error("interrupt alert not cleared by read");

	int_fire_c: cover property (@(posedge i_clk) disable iff (i_rst)
		hit && i_cfg.int_mode ##[1:300] i_rd_clear);
endmodule

/* File: tsa_master.sv */
/*
 * Behavioural two-wire bus master: start, stop, byte out and byte in.
 * Assumes the bench resolves SDA with a pull-up and feeds it back on i_sda.
 */
`timescale 1ns/1ns
module tsa_master
(
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_lo
);
	logic lclk;

	// ----------------------------------------
	// Link clock, 48 ns, unrelated to i_clk
	// ----------------------------------------
	initial
	begin
		lclk = 1'b0;
		o_scl = 1'b1;
		o_sda_lo = 1'b0;
		#7;
		forever #24 lclk = ~lclk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge lclk);
	endtask

	// Five ticks a phase: the slave needs four system clocks per level
	task automatic bit_io(input logic b, output logic r);
		tick(1);
		o_sda_lo = ~b;
		tick(4);
		o_scl = 1'b1;
		tick(3);
		r = i_sda;
		tick(2);
		o_scl = 1'b0;
	endtask

	// Works from idle and as a repeated start
	task automatic start();
		tick(1);
		o_sda_lo = 1'b0;
		tick(4);
		o_scl = 1'b1;
		tick(4);
		o_sda_lo = 1'b1;
		tick(5);
		o_scl = 1'b0;
	endtask

	// SCL then stands high until the next frame
	task automatic stop();
		tick(1);
		o_sda_lo = 1'b1;
		tick(4);
		o_scl = 1'b1;
		tick(5);
		o_sda_lo = 1'b0;
		tick(5);
	endtask

	task automatic put(input logic [7:0] v, output logic nack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(v[i], r);
		bit_io(1'b1, nack);
	endtask

	task automatic get(input logic last, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, v[i]);
		bit_io(last, r);
	endtask
endmodule

/* File: tsa_pkg.sv */
/*
 * Shared constants, types and helpers for the temperature sensor two-wire
 * slave and alert logic.
 * Assumes one system clock of 20 MHz and a bus clock that arrives on a pin.
 */
// Functional notes
// (RULE1) Fault queue code 00/01/10/11 needs 1/2/4/6 faults; resets to 00.
// (RULE2) Polarity bit 0 gives active-low alert, 1 active-high; resets 0.
// (RULE3) Mode bit 0 selects comparator, 1 interrupt; resets to comparator.
// (RULE4) Shutdown bit stops measuring but keeps the serial side alive.
// (RULE5) Limits are 16-bit two's complement, upper byte read first.
// (RULE6) Hysteresis limit resets to +75 degrees, over limit to +80.
// (RULE7) Bus address is 1001 followed by the three select pins.
// (RULE8) Address select pins are sampled continuously.
// (RULE9) 22.5 ms of SDA low abandons the transfer and releases SDA.
// (RULE10) The timeout only runs while SDA is low.
// (RULE11) Address shifts in MSB first; ACK only on own address.
// (RULE12) Direction bit 0 means write, 1 means read.
// (RULE13) Nine clocks per byte; data changes only while SCL is low.
// (RULE14) Master ends a read with NACK then stop.
// (RULE15) Master never mixes reads and writes without a new start.
// (RULE16) A pointer write selects the register later reads return.
// (RULE17) Config write has one data byte, limit write two.
// (RULE18) Config read returns one byte, word reads upper byte first.
// (RULE19) Alert powers up as over-temperature comparator.
// (RULE20) Comparator: active at or above over limit, off below hysteresis.
// (RULE21) Shutdown keeps the comparator alert state.
// (RULE22) Interrupt: fires after queued faults, any read clears it.
// (RULE23) Pointer low three bits select register; pointer resets to zero.
// (RULE24) Only consecutive over-limit measurements count as faults.
// (RULE25) A foreign address leaves SDA released until the next start.
package tsa_pkg;
	localparam logic [3:0]  ADDR_FIXED      = 4'h9;
	localparam logic [2:0]  PTR_TEMP        = 3'h0;
	localparam logic [2:0]  PTR_CFG         = 3'h1;
	localparam logic [2:0]  PTR_HYST        = 3'h2;
	localparam logic [2:0]  PTR_OVER        = 3'h3;
	localparam logic [2:0]  PTR_ONESHOT     = 3'h4;
	localparam logic [7:0]  CFG_RST         = 8'h00;
	localparam logic [15:0] HYST_RST        = 16'h4B00;
	localparam logic [15:0] OVER_RST        = 16'h5000;
	localparam logic [15:0] TEMP_RST        = 16'h0000;
	localparam logic [3:0]  BIT_LAST        = 4'h7;
	localparam logic [3:0]  BIT_ACK         = 4'h8;
	localparam logic [1:0]  IDX_PTR         = 2'h0;
	localparam logic [1:0]  IDX_HI          = 2'h1;
	localparam logic [1:0]  IDX_LO          = 2'h2;
	localparam int          CLK_FREQ_KHZ    = 20000;
	localparam int          SDA_TIMEOUT_US  = 22500;
	localparam int          SDA_TIMEOUT_CYC =
		SDA_TIMEOUT_US * (CLK_FREQ_KHZ / 1000);

	typedef struct packed
	{
		logic [1:0] rsvd;
		logic       oneshot;
		logic [1:0] fault_q;
		logic       pol_high;
		logic       int_mode;
		logic       shutdown;
	} tsa_cfg_t;

	typedef struct packed
	{
		logic [1:0] idx;
		logic [7:0] data;
	} tsa_wr_t;

	typedef enum logic [1:0]
	{
		ST_ADDR   = 2'b00,
		ST_WRITE  = 2'b01,
		ST_READ   = 2'b10,
		ST_IGNORE = 2'b11
	} tsa_st_t;

	function automatic logic [2:0] fault_need(input logic [1:0] code);
		case (code)
			2'h0:    fault_need = 3'h1;
			2'h1:    fault_need = 3'h2;
			2'h2:    fault_need = 3'h4;
			default: fault_need = 3'h6;
		endcase
	endfunction
endpackage

/* File: tsa_sync.sv */
/*
 * Two flip-flop level synchroniser, one bit per lane.
 * Assumes each lane is a slow level; multi-bit lanes must be quasi-static.
 */
`timescale 1ns/1ns
module tsa_sync
#(
	parameter int W = 1
)
(
	input  logic         i_clk,
	input  logic         i_rst,
	input  logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			meta_r <= '0;
			q_r    <= '0;
		end
		else
		begin
			meta_r <= i_d;
			q_r    <= meta_r;
		end
	end

	assign o_q = q_r;
endmodule

/* File: tsa_top.sv */
/*
 * Two-wire slave with configuration, limit and temperature registers,
 * feeding the over-temperature alert logic.
 * Assumes SCL bit periods of at least eight system clocks so that start,
 * stop and byte events cross safely; measurement strobes on i_clk.
 */
`timescale 1ns/1ns
module tsa_top
#(
	parameter int TIMEOUT_CYC = tsa_pkg::SDA_TIMEOUT_CYC
)
(
	input  logic        i_clk,
	input  logic        i_rst,
	input  logic        i_scl,
	input  logic        i_sda,
	output logic        o_sda_o,
	output logic        o_sda_oe_n,
	input  logic        i_addr_select_bit2,
	input  logic        i_addr_select_bit1,
	input  logic        i_addr_select_bit0,
	input  logic [15:0] i_temp,
	input  logic        i_temp_valid,
	output logic        o_overtemp_alert_output_o,
	output logic        o_overtemp_alert_output_oe_n,
	output logic        o_shutdown,
	output logic        o_oneshot
);
	import tsa_pkg::*;

	localparam int TW = $clog2(TIMEOUT_CYC + 1);

	//--------------------------------------------------------------
	// System domain: pin sampling, start, stop and timeout
	//--------------------------------------------------------------
	logic [1:0]  pin_s;
	logic        scl_s;
	logic        sda_s;
	logic        scl_d_r;
	logic        sda_d_r;
	logic        start_det;
	logic        stop_det;
	logic        active_r;
	logic        link_rst_r;
	logic [TW-1:0] to_cnt_r;
	logic        to_hit;
	logic [2:0]  addr_sel_s;

	tsa_sync #(.W(2)) u_pin_sync
	(
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   ({i_scl, i_sda}),
		.o_q   (pin_s)
	);

	tsa_sync #(.W(3)) u_addr_sync
	(
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   ({i_addr_select_bit2, i_addr_select_bit1,
		         i_addr_select_bit0}),
		.o_q   (addr_sel_s)                                    // RULE8
	);

	assign scl_s     = pin_s[1];
	assign sda_s     = pin_s[0];
	assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
	assign to_hit    = active_r && to_cnt_r == TW'(TIMEOUT_CYC - 1);

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			scl_d_r <= 1'b0;
			sda_d_r <= 1'b0;
		end
		else
		begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end

	// Only SDA held low counts; any SDA edge is activity, SCL edges are not
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			to_cnt_r <= '0;
		else if (!active_r || sda_s || sda_d_r)
			to_cnt_r <= '0;                                   // RULE10
		else
			to_cnt_r <= TW'(to_cnt_r + 1'b1);
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			active_r <= 1'b0;
		else if (start_det)
			active_r <= 1'b1;
		else if (stop_det || to_hit)
			active_r <= 1'b0;                                 // RULE9
	end

	// Holds the bit engine in reset while idle and pulses it at a start
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			link_rst_r <= 1'b1;
		else
			link_rst_r <= ~active_r | start_det | stop_det | to_hit;
	end

	//--------------------------------------------------------------
	// Link domain: bit engine on SCL
	//--------------------------------------------------------------
	logic        link_arst;
	tsa_st_t     st_r;
	logic [3:0]  bit_r;
	logic [6:0]  shift_r;
	logic [7:0]  byte_in;
	logic        rw_r;
	logic        ack_r;
	logic        freeze_r;
	logic        rd_lo_r;
	logic [7:0]  tx_r;
	logic [1:0]  wr_idx_r;
	tsa_wr_t     wr_ev_r;
	logic        wr_tog_r;
	logic        sda_oe_n_r;
	logic        own_match;
	logic [15:0] rd_word_r;

	assign link_arst = i_rst | link_rst_r;
	assign byte_in   = {shift_r, i_sda};
	// Pins are quasi-static while an address byte is on the bus
	assign own_match = byte_in[7:1] == {ADDR_FIXED, addr_sel_s}; // RULE7

	always_ff @(posedge i_scl or posedge link_arst)
	begin
		if (link_arst)
		begin
			bit_r   <= 4'h0;
			shift_r <= 7'h00;
		end
		else
		begin
			bit_r   <= (bit_r == BIT_ACK) ? 4'h0 : 4'(bit_r + 4'h1); // RULE13
			shift_r <= {shift_r[5:0], i_sda};                 // RULE11
		end
	end

	always_ff @(posedge i_scl or posedge link_arst)
	begin
		if (link_arst)
		begin
			st_r     <= ST_ADDR;
			ack_r    <= 1'b0;
			rw_r     <= 1'b0;
			freeze_r <= 1'b0;
		end
		else if (bit_r == BIT_LAST)
		begin
			case (st_r)
				ST_ADDR:
					if (own_match)
					begin
						ack_r    <= 1'b1;                         // RULE11
						rw_r     <= byte_in[0];                   // RULE12
						freeze_r <= byte_in[0];
					end
					else
						st_r <= ST_IGNORE;                        // RULE25
				ST_WRITE:
					ack_r <= 1'b1;
				default:
					ack_r <= 1'b0;
			endcase
		end
		else if (bit_r == BIT_ACK)
		begin
			ack_r <= 1'b0;
			case (st_r)
				ST_ADDR:
					st_r <= rw_r ? ST_READ : ST_WRITE;            // RULE12
				ST_READ:
					if (i_sda)
						st_r <= ST_IGNORE;                        // RULE14
				default:
					st_r <= st_r;
			endcase
		end
	end

	// Read bytes alternate upper then lower half of the frozen word
	always_ff @(posedge i_scl or posedge link_arst)
	begin
		if (link_arst)
		begin
			tx_r    <= 8'hFF;
			rd_lo_r <= 1'b0;
		end
		else if (bit_r == BIT_ACK &&
		         ((st_r == ST_ADDR && rw_r) || (st_r == ST_READ && !i_sda)))
		begin
			tx_r    <= rd_lo_r ? rd_word_r[7:0] : rd_word_r[15:8]; // RULE18
			rd_lo_r <= ~rd_lo_r;                              // RULE5
		end
		else if (st_r == ST_READ && bit_r != BIT_ACK)
			tx_r <= {tx_r[6:0], 1'b1};
	end

	always_ff @(posedge i_scl or posedge link_arst)
	begin
		if (link_arst)
		begin
			wr_idx_r <= IDX_PTR;
			wr_ev_r  <= '0;
		end
		else if (bit_r == BIT_LAST && st_r == ST_WRITE)
		begin
			wr_ev_r  <= '{idx: wr_idx_r, data: byte_in};      // RULE17
			wr_idx_r <= (wr_idx_r == 2'h3) ? wr_idx_r : 2'(wr_idx_r + 2'h1);
		end
	end

	// Toggle survives starts so the system side never sees a false event
	always_ff @(posedge i_scl or posedge i_rst)
	begin
		if (i_rst)
			wr_tog_r <= 1'b0;
		else if (bit_r == BIT_LAST && st_r == ST_WRITE)
			wr_tog_r <= ~wr_tog_r;
	end

	always_ff @(negedge i_scl or posedge link_arst)
	begin
		if (link_arst)
			sda_oe_n_r <= 1'b1;                               // RULE9
		else if (bit_r == BIT_ACK)
			sda_oe_n_r <= ~ack_r;
		else if (st_r == ST_READ)
			sda_oe_n_r <= tx_r[7];                            // RULE13
		else
			sda_oe_n_r <= 1'b1;                               // RULE25
	end

	assign o_sda_o    = 1'b0;
	assign o_sda_oe_n = sda_oe_n_r;

	//--------------------------------------------------------------
	// System domain: register file
	//--------------------------------------------------------------
	logic [1:0]  evt_s;
	logic        wr_tog_d_r;
	logic        freeze_d_r;
	logic        wr_evt;
	logic        rd_clear;
	logic [2:0]  pointer_sel_r;
	logic [7:0]  limit_hi_r;
	tsa_cfg_t    alert_configuration_r;
	logic [15:0] hysteresis_limit_r;
	logic [15:0] overtemp_limit_r;
	logic [15:0] temp_r;
	logic        oneshot_r;
	logic        shutdown_r;

	tsa_sync #(.W(2)) u_evt_sync
	(
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   ({wr_tog_r, freeze_r}),
		.o_q   (evt_s)
	);

	assign wr_evt   = evt_s[1] ^ wr_tog_d_r;
	assign rd_clear = evt_s[0] & ~freeze_d_r;

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			wr_tog_d_r <= 1'b0;
			freeze_d_r <= 1'b0;
		end
		else
		begin
			wr_tog_d_r <= evt_s[1];
			freeze_d_r <= evt_s[0];
		end
	end

	// Byte event data is stable for a whole byte time after the toggle
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			pointer_sel_r         <= PTR_TEMP;                // RULE23
			limit_hi_r            <= 8'h00;
			alert_configuration_r <= CFG_RST;                 // RULE1
			hysteresis_limit_r    <= HYST_RST;                // RULE6
			overtemp_limit_r      <= OVER_RST;
		end
		else if (wr_evt)
		begin
			if (wr_ev_r.idx == IDX_PTR)
				pointer_sel_r <= wr_ev_r.data[2:0];           // RULE16
			else if (wr_ev_r.idx == IDX_HI)
			begin
				limit_hi_r <= wr_ev_r.data;
				if (pointer_sel_r == PTR_CFG)
					alert_configuration_r <= wr_ev_r.data;    // RULE4
			end
			else if (wr_ev_r.idx == IDX_LO)
			begin
				if (pointer_sel_r == PTR_HYST)
					hysteresis_limit_r <= {limit_hi_r, wr_ev_r.data}; // RULE5
				else if (pointer_sel_r == PTR_OVER)
					overtemp_limit_r <= {limit_hi_r, wr_ev_r.data};
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			temp_r <= TEMP_RST;
		else if (i_temp_valid && !alert_configuration_r.shutdown)
			temp_r <= i_temp;
	end

	// Word is held while the link reads it, so both bytes match
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			rd_word_r <= TEMP_RST;
		else if (!evt_s[0])
		begin
			if (pointer_sel_r == PTR_TEMP)
				rd_word_r <= temp_r;
			else if (pointer_sel_r == PTR_CFG)
				rd_word_r <= {alert_configuration_r, 8'h00};
			else if (pointer_sel_r == PTR_HYST)
				rd_word_r <= hysteresis_limit_r;
			else if (pointer_sel_r == PTR_OVER)
				rd_word_r <= overtemp_limit_r;
			else
				rd_word_r <= 16'h0000;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			oneshot_r  <= 1'b0;
			shutdown_r <= 1'b0;
		end
		else
		begin
			oneshot_r  <= wr_evt && wr_ev_r.idx == IDX_PTR &&
			              wr_ev_r.data[2:0] == PTR_ONESHOT;
			shutdown_r <= alert_configuration_r.shutdown;
		end
	end

	assign o_oneshot  = oneshot_r;
	assign o_shutdown = shutdown_r;

	tsa_alert u_alert
	(
		.i_clk        (i_clk),
		.i_rst        (i_rst),
		.i_cfg        (alert_configuration_r),
		.i_temp       (i_temp),
		.i_temp_valid (i_temp_valid),
		.i_over       (overtemp_limit_r),
		.i_hyst       (hysteresis_limit_r),
		.i_rd_clear   (rd_clear),                             // RULE22
		.o_alert_oe_n (o_overtemp_alert_output_oe_n)
	);

	assign o_overtemp_alert_output_o = 1'b0;

	//--------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------
	timeout_abort_a: // RULE9
	assert property (@(posedge i_clk) disable iff (i_rst)
		to_hit && !start_det |=> !active_r && link_rst_r)
	else $error("timeout did not abandon transfer");

	sda_high_a: // RULE10
	assert property (@(posedge i_clk) disable iff (i_rst)
		sda_s |=> to_cnt_r == '0)
	else $error("timeout counted with SDA high");

	ptr_write_a: // RULE23
	assert property (@(posedge i_clk) disable iff (i_rst)
		wr_evt && wr_ev_r.idx == IDX_PTR
		|=> pointer_sel_r == $past(wr_ev_r.data[2:0]))
	else $error("pointer not loaded from first byte");

	limit_write_a: // RULE17
	assert property (@(posedge i_clk) disable iff (i_rst)
		wr_evt && wr_ev_r.idx == IDX_LO && pointer_sel_r == PTR_OVER
		|=> overtemp_limit_r == {$past(limit_hi_r), $past(wr_ev_r.data)})
	else $error("over limit not written from two bytes");

	foreign_addr_a: // RULE25
	assert property (@(posedge i_scl) disable iff (link_arst)
		bit_r == BIT_LAST && st_r == ST_ADDR && !own_match
		|=> st_r == ST_IGNORE ##1 sda_oe_n_r)
	else $error("foreign address not ignored");

	write_ack_a: // RULE13
	assert property (@(posedge i_scl) disable iff (link_arst)
		bit_r == BIT_LAST && st_r == ST_WRITE |=> !sda_oe_n_r)
	else $error("write byte not acknowledged");

	read_nack_a: // RULE14
	assert property (@(posedge i_scl) disable iff (link_arst)
		st_r == ST_READ && bit_r == BIT_ACK && i_sda |=> st_r == ST_IGNORE)
	else $error("read not ended on NACK");

	read_c: cover property (@(posedge i_scl) disable iff (link_arst)
		st_r == ST_READ && bit_r == BIT_ACK ##1 st_r == ST_READ);
	write_c: cover property (@(posedge i_clk) disable iff (i_rst)
		wr_evt && wr_ev_r.idx == IDX_LO);
	ignore_c: cover property (@(posedge i_scl) disable iff (link_arst)
		st_r == ST_IGNORE);
endmodule
